/* File: pkg/mwg_pkg.sv */
// package: register map, fields, warning codes and records of the run gate
package mwg_pkg;

    localparam int unsigned HIST_DEPTH = 9;
    localparam int unsigned SPEED_W = 16;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_INT_STAT  = 8'h08;
    localparam logic [7:0] OFF_INT_MASK  = 8'h0C;
    localparam logic [7:0] OFF_OVL_LEVEL = 8'h10;
    localparam logic [7:0] OFF_SPD_UPPER = 8'h14;
    localparam logic [7:0] OFF_SPD_LOWER = 8'h18;
    localparam logic [7:0] OFF_SPD_CMD   = 8'h1C;
    localparam logic [7:0] OFF_SPD_OUT   = 8'h20;
    localparam logic [7:0] OFF_HIST_CNT  = 8'h24;
    localparam logic [7:0] OFF_HIST_CLR  = 8'h28;
    localparam logic [7:0] OFF_INPUT_MAP = 8'h2C;
    localparam logic [7:0] OFF_HIST0     = 8'h40;

    // ctrl fields
    localparam int unsigned CTRL_EXT_LSB = 0;
    localparam int unsigned CTRL_LOCK_BIT = 2;

    // interrupt bits: 0 overheat, 1 overload, 2 operation error
    localparam int unsigned NUM_WARN = 3;

    localparam logic [1:0]  AXI_OKAY    = 2'h0;
    localparam logic [1:0]  AXI_SLVERR  = 2'h2;

    localparam logic [15:0] RST_SPD_UPPER = 16'h0FA0;
    localparam logic [15:0] RST_SPD_LOWER = 16'h0050;
    localparam logic [15:0] RST_OVL_LEVEL = 16'h0064;

    typedef enum logic [1:0] {
        MWG_EXT_OFF,
        MWG_EXT_ON,
        MWG_EXT_RE
    } mwg_ext_mode_t;

    typedef enum logic [1:0] {
        MWG_WARN_NONE,
        MWG_WARN_OVERHEAT,
        MWG_WARN_OVERLOAD,
        MWG_WARN_OPERR
    } mwg_warn_code_t;

    typedef struct packed {
        logic forward_run_input;
        logic reverse_run_input;
        logic panel_run;
        logic panel_standby_position;
        logic direction_switch_rev;
        logic overheat_detect;
        logic alarm_active;
    } mwg_pins_t;

endpackage

/* File: rtl/mwg_history.sv */
// nine-deep volatile warning history, newest in slot 0
`timescale 1ns/100ps
`default_nettype none
module mwg_history #(
    parameter int unsigned DEPTH = mwg_pkg::HIST_DEPTH
) (
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    input  wire logic                   push,
    input  wire mwg_pkg::mwg_warn_code_t push_code,
    input  wire logic                   clear,
    input  wire logic [3:0]             rd_index,
    output logic [1:0]                  rd_code,
    output logic [3:0]                  count
);
    initial begin
        if (DEPTH < 1 || DEPTH > 15) $error("history depth out of range");
    end

    typedef struct packed {
        logic [DEPTH-1:0][1:0] slot;
        logic [3:0]            cnt;
    } mwg_hist_state_t;

    mwg_hist_state_t st;
    mwg_hist_state_t next_st;

    // push beats clear in the same cycle so a fresh warning is never lost
    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.slot = '0;
            next_st.cnt  = 4'h0;
        end
        if (push) begin
            // shift down; the oldest falls off the end when full
            for (int i = DEPTH - 1; i > 0; i--) begin
                next_st.slot[i] = clear ? 2'h0 : st.slot[i-1];
            end
            next_st.slot[0] = push_code;
            if (clear) begin
                next_st.cnt = 4'h1;
            end else if (st.cnt < 4'(DEPTH)) begin
                next_st.cnt = st.cnt + 4'h1;
            end
        end
    end

    // volatile: plain reset empties it, as after power-up
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_code = (rd_index < 4'(DEPTH)) ? st.slot[rd_index] : 2'h0;
    assign count   = st.cnt;
endmodule
`default_nettype wire

/* File: rtl/mwg_sync.sv */
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none
module mwg_sync #(
    parameter int unsigned WIDTH = 7
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0]      q
);
    initial begin
        if (WIDTH < 1) $error("sync width must be positive");
    end

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } mwg_sync_state_t;

    mwg_sync_state_t st;
    mwg_sync_state_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule
`default_nettype wire

/* File: rtl/mwg_top.sv */
// motor warning and run gate: warnings, history, run decision, speed clamp, axi4-lite registers
//
// Contract
// - overheat raises warning, motor keeps running
// - load above level raises warning, keeps running
// - run mapped onto active input: error, stop
// - keep last nine warnings, newest first; of warnings rising in one cycle only the highest code is stored
// - clear command erases warning history
// - history empty after power-up
// - no drive while panel in standby
// - ext ON or RE ignores panel switch
// - ext OFF ignores external run inputs
// - external run needs exactly one direction input
// - active alarm inhibits operation
// - RE mode ignores direction switch
// - panel lock rejects dial setting changes
// - speed clamped to upper limit
// - speed clamped to lower limit
// - warning output high while any warning
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module mwg_top #(
    parameter int unsigned SPEED_W = mwg_pkg::SPEED_W
) (
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire mwg_pkg::mwg_pins_t        pins,
    input  wire logic [SPEED_W-1:0]        motor_load,
    input  wire logic                      dial_write,
    input  wire logic [SPEED_W-1:0]        dial_speed,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output logic [1:0]                     s_axi_bresp,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    input  wire logic [7:0]                s_axi_araddr,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           motor_run,
    output logic                           motor_dir_rev,
    output logic [SPEED_W-1:0]             speed_out,
    output logic                           warning_output,
    output logic                           irq
);
    initial begin
        if (SPEED_W < 8 || SPEED_W > 32) $error("speed width out of range");
    end

    localparam int unsigned NW = mwg_pkg::NUM_WARN;
    localparam int unsigned PW = $bits(mwg_pkg::mwg_pins_t);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                aw_got;
        logic                w_got;
        logic [7:0]          awaddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        mwg_pkg::mwg_ext_mode_t ext_mode;
        logic                lock;
        logic [NW-1:0]       int_stat;
        logic [NW-1:0]       int_mask;
        logic [SPEED_W-1:0]  ovl_level;
        logic [SPEED_W-1:0]  spd_upper;
        logic [SPEED_W-1:0]  spd_lower;
        logic [SPEED_W-1:0]  spd_cmd;
        logic [2:0]          run_map;
        logic                op_error;
        logic [NW-1:0]       warn_prev;
        logic                run;
        logic                dir_rev;
        logic [SPEED_W-1:0]  speed;
        logic                warn_out;
        logic                irq;
    } mwg_state_t;

    mwg_state_t st;
    mwg_state_t next_st;

    mwg_pkg::mwg_pins_t    pins_s;
    logic [PW-1:0]         pins_q;
    logic [3:0]            hist_cnt;
    logic [1:0]            hist_code;
    logic [3:0]            hist_idx;
    logic                  hist_push;
    logic                  hist_clear;
    mwg_pkg::mwg_warn_code_t hist_push_code;
    logic [NW-1:0]         warn_now;
    logic [NW-1:0]         warn_rise;
    logic [2:0]            input_levels;

    // pins come from switches outside the clock domain
    mwg_sync #(.WIDTH(PW)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       (pins),
        .q       (pins_q)
    );
    assign pins_s = mwg_pkg::mwg_pins_t'(pins_q);

    function automatic logic [SPEED_W-1:0] wmask(input logic [SPEED_W-1:0] old,
                                                 input logic [31:0] d, input logic [3:0] be);
        logic [31:0] r;
        r = 32'(old);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r[SPEED_W-1:0];
    endfunction

    // clamp applies to both dial and register sources
    function automatic logic [SPEED_W-1:0] clamp(input logic [SPEED_W-1:0] v,
                                                 input logic [SPEED_W-1:0] lo, input logic [SPEED_W-1:0] hi);
        if (v > hi) return hi;
        if (v < lo) return lo;
        return v;
    endfunction

    // ------------------------------------------------------------
    // warnings and history feed
    // ------------------------------------------------------------
    // terminals carrying run function: fwd, rev, panel run
    assign input_levels = {pins_s.panel_run, pins_s.reverse_run_input, pins_s.forward_run_input};
    assign warn_now[0] = pins_s.overheat_detect;
    assign warn_now[1] = motor_load > st.ovl_level;
    assign warn_now[2] = st.op_error;
    assign warn_rise   = warn_now & ~st.warn_prev;
    assign hist_push   = |warn_rise;

    always_comb begin
        hist_push_code = mwg_pkg::MWG_WARN_NONE;
        if (warn_rise[2]) begin
            hist_push_code = mwg_pkg::MWG_WARN_OPERR;
        end else if (warn_rise[1]) begin
            hist_push_code = mwg_pkg::MWG_WARN_OVERLOAD;
        end else if (warn_rise[0]) begin
            hist_push_code = mwg_pkg::MWG_WARN_OVERHEAT;
        end
    end

    mwg_history #(.DEPTH(mwg_pkg::HIST_DEPTH)) u_hist (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .push      (hist_push),
        .push_code (hist_push_code),
        .clear     (hist_clear),
        .rd_index  (hist_idx),
        .rd_code   (hist_code),
        .count     (hist_cnt)
    );

    // ------------------------------------------------------------
    // axi handshake and decode
    // ------------------------------------------------------------
    logic        wr_fire;
    logic [7:0]  wr_addr;
    logic [7:0]  rd_addr;
    logic        rd_fire;

    assign wr_fire  = st.aw_got && st.w_got && !st.bvalid;
    assign wr_addr  = st.awaddr;
    assign rd_fire  = s_axi_arvalid && st.arready;
    assign rd_addr  = s_axi_araddr;
    assign hist_clear = wr_fire && wr_addr == mwg_pkg::OFF_HIST_CLR && st.wdata[0];
    assign hist_idx = 4'((rd_addr - mwg_pkg::OFF_HIST0) >> 2);

    always_comb begin
        logic run_cmd;
        logic new_map_hit;
        logic [NW-1:0] set_bits;
        run_cmd     = 1'b0;
        new_map_hit = 1'b0;
        set_bits    = '0;
        next_st     = st;

        // write address and data channels, in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got  = 1'b1;
            next_st.awaddr  = s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got  = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
            next_st.wready = 1'b0;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end

        set_bits = warn_rise;
        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = mwg_pkg::AXI_OKAY;
            if (wr_addr == mwg_pkg::OFF_CTRL) begin
                if (st.wstrb[0]) begin
                    next_st.ext_mode = mwg_pkg::mwg_ext_mode_t'(st.wdata[mwg_pkg::CTRL_EXT_LSB +: 2]);
                    next_st.lock     = st.wdata[mwg_pkg::CTRL_LOCK_BIT];
                end
            end else if (wr_addr == mwg_pkg::OFF_INT_STAT) begin
                if (st.wstrb[0]) next_st.int_stat = st.int_stat & ~st.wdata[NW-1:0];
            end else if (wr_addr == mwg_pkg::OFF_INT_MASK) begin
                if (st.wstrb[0]) next_st.int_mask = st.wdata[NW-1:0];
            end else if (wr_addr == mwg_pkg::OFF_OVL_LEVEL) begin
                next_st.ovl_level = wmask(st.ovl_level, st.wdata, st.wstrb);
            end else if (wr_addr == mwg_pkg::OFF_SPD_UPPER) begin
                next_st.spd_upper = wmask(st.spd_upper, st.wdata, st.wstrb);
            end else if (wr_addr == mwg_pkg::OFF_SPD_LOWER) begin
                next_st.spd_lower = wmask(st.spd_lower, st.wdata, st.wstrb);
            end else if (wr_addr == mwg_pkg::OFF_SPD_CMD) begin
                next_st.spd_cmd = wmask(st.spd_cmd, st.wdata, st.wstrb);
            end else if (wr_addr == mwg_pkg::OFF_INPUT_MAP) begin
                if (st.wstrb[0]) begin
                    next_st.run_map = st.wdata[2:0];
                    new_map_hit = |(st.wdata[2:0] & ~st.run_map & input_levels);
                end
            end else if (wr_addr == mwg_pkg::OFF_HIST_CLR) begin
                next_st.bresp = mwg_pkg::AXI_OKAY;
            end else begin
                next_st.bresp = mwg_pkg::AXI_SLVERR;
            end
        end
        // set wins over a clear in the same cycle
        next_st.int_stat = next_st.int_stat | set_bits;

        // dial entry is refused while the panel is locked
        if (dial_write && !st.lock) begin
            next_st.spd_cmd = dial_speed;
        end

        // read channel
        if (rd_fire) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = mwg_pkg::AXI_OKAY;
            next_st.rdata   = 32'h0000_0000;
            if (rd_addr == mwg_pkg::OFF_CTRL) begin
                next_st.rdata = 32'({st.lock, st.ext_mode});
            end else if (rd_addr == mwg_pkg::OFF_STATUS) begin
                next_st.rdata = 32'({st.warn_out, st.dir_rev, st.run});
            end else if (rd_addr == mwg_pkg::OFF_INT_STAT) begin
                next_st.rdata = 32'(st.int_stat);
            end else if (rd_addr == mwg_pkg::OFF_INT_MASK) begin
                next_st.rdata = 32'(st.int_mask);
            end else if (rd_addr == mwg_pkg::OFF_OVL_LEVEL) begin
                next_st.rdata = 32'(st.ovl_level);
            end else if (rd_addr == mwg_pkg::OFF_SPD_UPPER) begin
                next_st.rdata = 32'(st.spd_upper);
            end else if (rd_addr == mwg_pkg::OFF_SPD_LOWER) begin
                next_st.rdata = 32'(st.spd_lower);
            end else if (rd_addr == mwg_pkg::OFF_SPD_CMD) begin
                next_st.rdata = 32'(st.spd_cmd);
            end else if (rd_addr == mwg_pkg::OFF_SPD_OUT) begin
                next_st.rdata = 32'(st.speed);
            end else if (rd_addr == mwg_pkg::OFF_HIST_CNT) begin
                next_st.rdata = 32'(hist_cnt);
            end else if (rd_addr == mwg_pkg::OFF_HIST_CLR) begin
                next_st.rdata = 32'h0000_0000;
            end else if (rd_addr == mwg_pkg::OFF_INPUT_MAP) begin
                next_st.rdata = 32'(st.run_map);
            end else if (rd_addr >= mwg_pkg::OFF_HIST0 && rd_addr[1:0] == 2'h0
                         && ((rd_addr - mwg_pkg::OFF_HIST0) >> 2) < 8'(mwg_pkg::HIST_DEPTH)) begin
                next_st.rdata = 32'(hist_code);
            end else begin
                next_st.rresp = mwg_pkg::AXI_SLVERR;
            end
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end

        // operation error latches until run inputs all drop
        if (new_map_hit) begin
            next_st.op_error = 1'b1;
        end else if (!(|input_levels)) begin
            next_st.op_error = 1'b0;
        end
        next_st.warn_prev = warn_now;

        // run decision
        if (st.ext_mode == mwg_pkg::MWG_EXT_OFF) begin
            run_cmd = pins_s.panel_run;
            next_st.dir_rev = pins_s.direction_switch_rev;
        end else begin
            // panel switch is not a run source here
            run_cmd = pins_s.forward_run_input ^ pins_s.reverse_run_input;
            if (st.ext_mode == mwg_pkg::MWG_EXT_RE) begin
                next_st.dir_rev = pins_s.reverse_run_input;
            end else begin
                next_st.dir_rev = pins_s.reverse_run_input ^ pins_s.direction_switch_rev;
            end
        end
        // overheat and overload leave run alone; alarm and op error stop it
        next_st.run = run_cmd && !pins_s.panel_standby_position && !pins_s.alarm_active
                      && !st.op_error && !new_map_hit;

        next_st.speed    = clamp(st.spd_cmd, st.spd_lower, st.spd_upper);
        next_st.warn_out = |warn_now;
        next_st.irq      = |(next_st.int_stat & st.int_mask);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st           <= '0;
            st.awready   <= 1'b1;
            st.wready    <= 1'b1;
            st.arready   <= 1'b1;
            st.spd_upper <= SPEED_W'(mwg_pkg::RST_SPD_UPPER);
            st.spd_lower <= SPEED_W'(mwg_pkg::RST_SPD_LOWER);
            st.ovl_level <= SPEED_W'(mwg_pkg::RST_OVL_LEVEL);
            st.speed     <= SPEED_W'(mwg_pkg::RST_SPD_LOWER);
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready  = st.awready;
    assign s_axi_wready   = st.wready;
    assign s_axi_bvalid   = st.bvalid;
    assign s_axi_bresp    = st.bresp;
    assign s_axi_arready  = st.arready;
    assign s_axi_rvalid   = st.rvalid;
    assign s_axi_rdata    = st.rdata;
    assign s_axi_rresp    = st.rresp;
    assign motor_run      = st.run;
    assign motor_dir_rev  = st.dir_rev;
    assign speed_out      = st.speed;
    assign warning_output = st.warn_out;
    assign irq            = st.irq;
endmodule
`default_nettype wire

/* File: sim/mwg_switch_model.sv */
// switch and relay model in front of the pins
`timescale 1ns/100ps
`default_nettype none
module mwg_switch_model (
    input  wire logic [6:0]       sw,
    output var mwg_pkg::mwg_pins_t pins
);
    // ideal contacts: no bounce modelled
    assign pins = sw;
endmodule
`default_nettype wire

/* File: sim/mwg_top_properties.sv */
// port assertions for the run gate
`timescale 1ns/100ps
`default_nettype none
module mwg_top_properties (
    input wire logic               clk_sys,
    input wire logic               reset,
    input wire mwg_pkg::mwg_pins_t pins,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic [1:0]         s_axi_rresp,
    input wire logic               motor_run,
    input wire logic               warning_output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write side not busy");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read side not busy");
    a_error_data: assert property (s_axi_rvalid && s_axi_rresp == mwg_pkg::AXI_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read data");
    a_standby_stop: assert property (pins.panel_standby_position [*4] |-> !motor_run)
        else $error("motor runs in standby");
    a_alarm_stop: assert property (pins.alarm_active [*4] |-> !motor_run)
        else $error("motor runs under alarm");
    a_heat_warn: assert property (pins.overheat_detect [*4] |-> warning_output)
        else $error("no overheat warning");
endmodule
bind mwg_top mwg_top_properties u_props (.clk_sys, .reset, .pins, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
    .motor_run, .warning_output);
`default_nettype wire

/* File: sim/mwg_top_tb.sv */
// self-checking bench for the run gate
`timescale 1ns/100ps
`default_nettype none
module mwg_top_tb;
    logic        clk_sys, reset, dial_write, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        motor_run, motor_dir_rev, warning_output, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [15:0] motor_load, dial_speed, speed_out;
    logic [6:0]  sw, pins;
    int          bad_count, cmp_count, cyc;

    mwg_switch_model u_sw (.sw(sw), .pins(pins));
    mwg_top dut (.clk_sys, .reset, .pins, .motor_load, .dial_write, .dial_speed, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .motor_run, .motor_dir_rev, .speed_out, .warning_output, .irq);

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // ceiling far above the few hundred cycles used
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge clk_sys); while (s_axi_wready !== 1'b1);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        chk("bresp", 32'h0, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
        chk(n, e, rdv);
    endtask
    // e is {run, reverse}; direction judged only while running
    task automatic pin(input logic [6:0] v, input logic [1:0] e);
        sw <= v;
        wt(5);
        chk("run_dir", {30'h0, e}, {30'h0, motor_run, e[1] ? motor_dir_rev : 1'b0});
    endtask
    task automatic dial(input logic [15:0] v, input logic [15:0] e);
        dial_speed <= v;
        dial_write <= 1'b1;
        @(posedge clk_sys);
        dial_write <= 1'b0;
        wt(4);
        chk("speed_out", {16'h0, e}, {16'h0, speed_out});
    endtask

    task automatic t_reset;
        rchk("spd_upper", mwg_pkg::OFF_SPD_UPPER, {16'h0, mwg_pkg::RST_SPD_UPPER});
        rchk("hist_cnt", mwg_pkg::OFF_HIST_CNT, 32'h0);
        rchk("unmapped", 8'hFC, 32'h0);
        chk("unmapped_resp", {30'h0, mwg_pkg::AXI_SLVERR}, {30'h0, rsp});
        chk("speed_rst", {16'h0, mwg_pkg::RST_SPD_LOWER}, {16'h0, speed_out});
        $display("reset done");
    endtask
    task automatic t_run;
        pin(7'h10, 2'b10);
        pin(7'h18, 2'b00);
        pin(7'h70, 2'b10);
        wr(mwg_pkg::OFF_CTRL, 32'h1);
        pin(7'h10, 2'b00);
        pin(7'h50, 2'b10);
        pin(7'h70, 2'b00);
        pin(7'h30, 2'b11);
        pin(7'h54, 2'b11);
        pin(7'h51, 2'b00);
        wr(mwg_pkg::OFF_CTRL, 32'h2);
        pin(7'h54, 2'b10);
        pin(7'h00, 2'b00);
        $display("run gate done");
    endtask
    task automatic t_speed;
        wr(mwg_pkg::OFF_SPD_UPPER, 32'h100);
        wr(mwg_pkg::OFF_SPD_LOWER, 32'h20);
        dial(16'h200, 16'h100);
        dial(16'h10, 16'h20);
        dial(16'h80, 16'h80);
        wr(mwg_pkg::OFF_CTRL, 32'h4);
        dial(16'h90, 16'h80);
        $display("speed done");
    endtask
    task automatic t_warn;
        wr(mwg_pkg::OFF_CTRL, 32'h1);
        wr(mwg_pkg::OFF_INPUT_MAP, 32'h0);
        pin(7'h52, 2'b10);
        chk("warn_out", 32'h1, {31'h0, warning_output});
        motor_load <= 16'h0065;
        pin(7'h50, 2'b10);
        rchk("int_stat", mwg_pkg::OFF_INT_STAT, 32'h3);
        motor_load <= 16'h0064;
        wr(mwg_pkg::OFF_INPUT_MAP, 32'h1);
        pin(7'h50, 2'b00);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rchk("hist0", mwg_pkg::OFF_HIST0, 32'h3);
        rchk("hist2", mwg_pkg::OFF_HIST0 + 8'h08, 32'h1);
        wr(mwg_pkg::OFF_INT_MASK, 32'h4);
        wt(2);
        chk("irq", 32'h1, {31'h0, irq});
        pin(7'h10, 2'b00);
        wr(mwg_pkg::OFF_INT_STAT, 32'h7);
        wt(2);
        chk("irq_clr", 32'h0, {31'h0, irq});
        for (int i = 0; i < 7; i++) begin
            pin(7'h12, 2'b00);
            pin(7'h10, 2'b00);
        end
        rchk("hist_full", mwg_pkg::OFF_HIST_CNT, 32'h9);
        rchk("hist8", mwg_pkg::OFF_HIST0 + 8'h20, 32'h2);
        wr(mwg_pkg::OFF_HIST_CLR, 32'h1);
        rchk("hist_clr", mwg_pkg::OFF_HIST_CNT, 32'h0);
        $display("warnings done");
    endtask

    initial begin
        {reset, dial_write, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h40;
        {sw, motor_load, dial_speed, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_run();
        t_speed();
        t_warn();
        end_of_test();
    end
endmodule
`default_nettype wire
